// ===== shc_pkg.sv
// Constants and carrier types shared by the health control register block.
// Assumes the host I/O space decode for the block base is done outside.
`default_nettype none
package shc_pkg;
   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam int          ADDR_W        = 8;
   localparam int          DATA_W        = 16;
   localparam logic [7:0]  CTRL_ONE_OFS  = 8'h08;
   localparam logic [7:0]  CTRL_TWO_OFS  = 8'h0a;
   localparam logic [15:0] CTRL_ONE_RST  = 16'h0000;
   localparam logic [15:0] CTRL_TWO_RST  = 16'h0008;

   // Field positions
   localparam int          HALT_BIT      = 11;
   localparam int          SEND_BIT      = 10;
   localparam int          REDIR_BIT     = 9;
   localparam int          FNMI_BIT      = 8;
   localparam int          ALDIS_BIT     = 3;
   localparam int          INTR_HI       = 2;
   localparam int          INTR_LO       = 1;
   localparam int          LANE_HI       = 1;
   localparam int          LANE_LO       = 0;

   // Intrusion action encodings
   localparam logic [1:0]  INTR_NONE     = 2'h0;
   localparam logic [1:0]  INTR_IRQ      = 2'h1;
   localparam logic [1:0]  INTR_MGMT     = 2'h2;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {MSG_IDLE, MSG_SEND} shc_msg_state_t;

   // Host I/O access
   typedef struct packed {
      logic [7:0]  addr;
      logic        wr;
      logic        rd;
      logic [1:0]  be;
      logic [15:0] wdata;
   } shc_io_req_t;

   // Core well state, including the core well control register bits
   typedef struct packed {
      logic           watchdog_halt;
      logic           send_request;
      logic           nmi_redirect_enable;
      logic           forced_nmi;
      shc_msg_state_t msg_state;
      logic           msg_is_sw;
      logic           msg_start;
      logic           msg_sw_event;
      logic           lan_reset;
      logic           nmi_out;
      logic           mgmt_interrupt_n;
      logic           intr_irq;
      logic           reboot_enable;
      logic           count_enable;
      logic           heartbeat_send;
      logic           intrusion_prev;
      logic [15:0]    rdata;
   } shc_core_t;

   // Resume well state
   typedef struct packed {
      logic       alert_pin_disable;
      logic [1:0] intrusion_action;
   } shc_resume_t;
endpackage
`default_nettype wire

// ===== shc_rst_sync.sv
// Two-flop release synchroniser for an active-low asynchronous reset.
// Assumes the reset input may change at any time relative to the clock.
`default_nettype none
module shc_rst_sync (
   input  wire logic clk_sys,
   input  wire logic rst_in_n,
   output logic      rst_out_n
);
   logic [1:0] sync_reg;

   always_ff @(posedge clk_sys or negedge rst_in_n) begin
      if (!rst_in_n) begin
         sync_reg <= 2'h0;
      end else begin
         sync_reg <= {sync_reg[0], 1'b1};
      end
   end

   assign rst_out_n = sync_reg[1];
endmodule
`default_nettype wire

// ===== shc_health_ctrl.sv
// Health control registers: watchdog halt, message request, NMI steering,
// forced NMI, alert pin disable and intrusion action.
// Assumes all inputs but the two resets are synchronous to clk_sys and the base decode is external.
`default_nettype none
module shc_health_ctrl (
   input  wire logic                clk_sys,
   input  wire logic                nrst,
   input  wire logic                resume_reset_n,
   input  wire shc_pkg::shc_io_req_t io_req,
   output logic [15:0]              io_rdata,
   input  wire logic                msg_done,
   input  wire logic                hw_event_req,
   input  wire logic                heartbeat_tick,
   output logic                     msg_start,
   output logic                     msg_sw_event,
   output logic                     heartbeat_send,
   output logic                     lan_reset,
   output logic                     watchdog_count_enable,
   output logic                     reboot_enable,
   input  wire logic                nmi_event,
   input  wire logic                nmi_enable,
   input  wire logic                global_mgmt_irq_enable,
   output logic                     nmi_out,
   output logic                     mgmt_interrupt_n,
   input  wire logic                bus_alert_n,
   output logic                     alert_event,
   output logic                     alert_source_enable,
   input  wire logic                intrusion_active,
   output logic                     intrusion_irq,
   output logic [1:0]               health_irq_route_sel,
   input  wire logic [1:0]          health_irq_route
);
   // ****************************************************************
   // Resets
   // ****************************************************************
   logic core_rst_n;
   logic resume_rst_n;

   shc_rst_sync u_core_rst (
      .clk_sys   (clk_sys),
      .rst_in_n  (nrst),
      .rst_out_n (core_rst_n)
   );

   shc_rst_sync u_resume_rst (
      .clk_sys   (clk_sys),
      .rst_in_n  (resume_reset_n),
      .rst_out_n (resume_rst_n)
   );

   // ****************************************************************
   // Access decode
   // ****************************************************************
   logic wr_one_hi;
   logic wr_two_lo;
   logic rd_one;
   logic rd_two;

   always_comb begin
      wr_one_hi = 1'b0;
      wr_two_lo = 1'b0;
      rd_one    = 1'b0;
      rd_two    = 1'b0;
      if (io_req.addr == shc_pkg::CTRL_ONE_OFS) begin
         wr_one_hi = io_req.wr && io_req.be[shc_pkg::LANE_HI];
         rd_one    = io_req.rd;
      end else if (io_req.addr == shc_pkg::CTRL_TWO_OFS) begin
         wr_two_lo = io_req.wr && io_req.be[shc_pkg::LANE_LO];
         rd_two    = io_req.rd;
      end
   end

   // ****************************************************************
   // Core well state
   // ****************************************************************
   shc_pkg::shc_core_t   c_reg;
   shc_pkg::shc_core_t   c_next;
   shc_pkg::shc_resume_t r_reg;
   shc_pkg::shc_resume_t r_next;
   logic [15:0]          one_view;
   logic [15:0]          two_view;
   logic                 intrusion_rise;

   always_comb begin
      one_view                          = 16'h0000;
      one_view[shc_pkg::HALT_BIT]       = c_reg.watchdog_halt;
      one_view[shc_pkg::SEND_BIT]       = c_reg.send_request;
      one_view[shc_pkg::REDIR_BIT]      = c_reg.nmi_redirect_enable;
      one_view[shc_pkg::FNMI_BIT]       = c_reg.forced_nmi;
      two_view                          = 16'h0000;
      two_view[shc_pkg::ALDIS_BIT]      = r_reg.alert_pin_disable;
      two_view[shc_pkg::INTR_HI:shc_pkg::INTR_LO] = r_reg.intrusion_action;
   end

   assign intrusion_rise = intrusion_active && !c_reg.intrusion_prev;

   always_comb begin
      c_next           = c_reg;
      c_next.msg_start = 1'b0;
      c_next.lan_reset = 1'b0;
      c_next.nmi_out   = 1'b0;
      c_next.intr_irq  = 1'b0;
      c_next.mgmt_interrupt_n = 1'b1;
      c_next.heartbeat_send   = heartbeat_tick;
      c_next.intrusion_prev   = intrusion_active;
      if (wr_one_hi) begin
         c_next.watchdog_halt       = io_req.wdata[shc_pkg::HALT_BIT];
         c_next.nmi_redirect_enable = io_req.wdata[shc_pkg::REDIR_BIT];
         // Writing one takes effect only with no request pending; a pending request is left alone
         if (io_req.wdata[shc_pkg::SEND_BIT] && !c_reg.send_request) begin
            c_next.send_request = 1'b1;
            c_next.lan_reset    = 1'b1;
         end
         if (io_req.wdata[shc_pkg::FNMI_BIT]) begin
            if (c_reg.forced_nmi) begin
               c_next.forced_nmi = 1'b0;
            end else begin
               c_next.forced_nmi = 1'b1;
               c_next.nmi_out    = 1'b1;
            end
         end
      end
      c_next.count_enable  = !c_next.watchdog_halt;
      c_next.reboot_enable = !c_next.watchdog_halt;
      // NMI steering
      if (nmi_event) begin
         if (c_reg.nmi_redirect_enable) begin
            c_next.mgmt_interrupt_n = !(global_mgmt_irq_enable && !nmi_enable);
         end else begin
            c_next.nmi_out = 1'b1;
         end
      end
      // Intrusion action
      if (intrusion_rise) begin
         case (r_reg.intrusion_action)
            shc_pkg::INTR_IRQ:  c_next.intr_irq = 1'b1;
            shc_pkg::INTR_MGMT: c_next.mgmt_interrupt_n = 1'b0;
            default:            c_next.intr_irq = 1'b0;
         endcase
      end
      // Message sender: a halted watchdog holds event messages back
      case (c_reg.msg_state)
         shc_pkg::MSG_IDLE: begin
            if (!c_reg.watchdog_halt) begin
               if (c_reg.send_request) begin
                  c_next.msg_start    = 1'b1;
                  c_next.msg_sw_event = 1'b1;
                  c_next.msg_is_sw    = 1'b1;
                  c_next.msg_state    = shc_pkg::MSG_SEND;
               end else if (hw_event_req) begin
                  c_next.msg_start    = 1'b1;
                  c_next.msg_sw_event = 1'b0;
                  c_next.msg_is_sw    = 1'b0;
                  c_next.msg_state    = shc_pkg::MSG_SEND;
               end
            end
         end
         default: begin
            if (msg_done) begin
               c_next.msg_state = shc_pkg::MSG_IDLE;
               if (c_reg.msg_is_sw) begin
                  c_next.send_request = 1'b0;
               end
            end
         end
      endcase
      c_next.rdata = rd_one ? one_view : (rd_two ? two_view : 16'h0000);
   end

   always_ff @(posedge clk_sys or negedge core_rst_n) begin
      if (!core_rst_n) begin
         c_reg                  <= '0;
         c_reg.watchdog_halt    <= shc_pkg::CTRL_ONE_RST[shc_pkg::HALT_BIT];
         c_reg.count_enable     <= 1'b1;
         c_reg.reboot_enable    <= 1'b1;
         c_reg.mgmt_interrupt_n <= 1'b1;
         c_reg.msg_state        <= shc_pkg::MSG_IDLE;
      end else begin
         c_reg <= c_next;
      end
   end

   // ****************************************************************
   // Resume well state
   // ****************************************************************
   always_comb begin
      r_next = r_reg;
      if (wr_two_lo) begin
         r_next.alert_pin_disable = io_req.wdata[shc_pkg::ALDIS_BIT];
         r_next.intrusion_action  = io_req.wdata[shc_pkg::INTR_HI:shc_pkg::INTR_LO];
      end
   end

   // Alert output kept in the resume domain flop set it is gated by
   logic alert_event_reg;

   always_ff @(posedge clk_sys or negedge resume_rst_n) begin
      if (!resume_rst_n) begin
         r_reg.alert_pin_disable <= shc_pkg::CTRL_TWO_RST[shc_pkg::ALDIS_BIT];
         r_reg.intrusion_action  <= shc_pkg::CTRL_TWO_RST[shc_pkg::INTR_HI:shc_pkg::INTR_LO];
         alert_event_reg         <= 1'b0;
      end else begin
         r_reg           <= r_next;
         alert_event_reg <= !bus_alert_n && !r_next.alert_pin_disable;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   logic [1:0] route_reg;

   always_ff @(posedge clk_sys or negedge core_rst_n) begin
      if (!core_rst_n) begin
         route_reg <= 2'h0;
      end else begin
         route_reg <= health_irq_route;
      end
   end

   assign io_rdata              = c_reg.rdata;
   assign msg_start             = c_reg.msg_start;
   assign msg_sw_event          = c_reg.msg_sw_event;
   assign heartbeat_send        = c_reg.heartbeat_send;
   assign lan_reset             = c_reg.lan_reset;
   assign watchdog_count_enable = c_reg.count_enable;
   assign reboot_enable         = c_reg.reboot_enable;
   assign nmi_out               = c_reg.nmi_out;
   assign mgmt_interrupt_n      = c_reg.mgmt_interrupt_n;
   assign intrusion_irq         = c_reg.intr_irq;
   assign health_irq_route_sel  = route_reg;
   assign alert_event           = alert_event_reg;
   assign alert_source_enable   = !r_reg.alert_pin_disable;
endmodule
`default_nettype wire

// ===== shc_health_ctrl_properties.sv
// Concurrent checks on the ports of the health control register block.
// Assumes binding to shc_health_ctrl; both resets quiet the checks.
`default_nettype none
module shc_hc_props (
   input wire logic                 clk_sys,
   input wire logic                 nrst,
   input wire logic                 resume_reset_n,
   input wire shc_pkg::shc_io_req_t io_req,
   input wire logic [15:0]          io_rdata,
   input wire logic                 heartbeat_tick,
   input wire logic                 heartbeat_send,
   input wire logic                 msg_start,
   input wire logic                 lan_reset,
   input wire logic                 watchdog_count_enable,
   input wire logic                 reboot_enable,
   input wire logic                 nmi_event,
   input wire logic                 nmi_enable,
   input wire logic                 global_mgmt_irq_enable,
   input wire logic                 nmi_out,
   input wire logic                 mgmt_interrupt_n,
   input wire logic                 bus_alert_n,
   input wire logic                 alert_event,
   input wire logic                 alert_source_enable,
   input wire logic                 intrusion_active,
   input wire logic                 intrusion_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic w_one;
   logic r_one;
   assign w_one = io_req.wr && io_req.addr == shc_pkg::CTRL_ONE_OFS && io_req.be[1];
   assign r_one = io_req.rd && io_req.addr == shc_pkg::CTRL_ONE_OFS;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst || !resume_reset_n);
   chk_halt_stop:
      assert property (w_one && io_req.wdata[11] |-> ##[1:2] !watchdog_count_enable && !reboot_enable)
      else $error("halt left counter running");
   chk_beat_on:
      assert property (heartbeat_tick |=> heartbeat_send) else $error("heartbeat lost");
   chk_lan_cause:
      assert property (lan_reset |-> $past(w_one) && $past(io_req.wdata[10]))
      else $error("network reset without send write");
   chk_nmi_cause:
      assert property (nmi_out |-> $past(nmi_event) || $past(w_one) && $past(io_req.wdata[8]))
      else $error("nmi without cause");
   chk_mgmt_cause:
      assert property (!mgmt_interrupt_n |-> $past(nmi_event) && $past(global_mgmt_irq_enable)
         && !$past(nmi_enable) || $past(intrusion_active) && !$past(intrusion_active, 2))
      else $error("management interrupt without cause");
   chk_rsvd_one:
      assert property (r_one |=> io_rdata[15:12] == 4'h0 && io_rdata[7:0] == 8'h00)
      else $error("reserved bits read nonzero");
   chk_alert_src:
      assert property (alert_event |-> !$past(bus_alert_n)) else $error("alert without pin");
   chk_alert_reset:
      assert property ($rose(resume_reset_n) |-> !alert_source_enable && !alert_event)
      else $error("alert pin enabled out of reset");
   chk_intr_rise:
      assert property (intrusion_irq |-> $past(intrusion_active) && !$past(intrusion_active, 2))
      else $error("intrusion interrupt without rising input");
   cov_send: cover property (lan_reset ##[1:4] msg_start);
   cov_nmi: cover property (nmi_out);
   cov_mgmt_low: cover property (!mgmt_interrupt_n);
endmodule
bind shc_health_ctrl shc_hc_props chk_u (.clk_sys, .nrst, .resume_reset_n, .io_req, .io_rdata,
   .heartbeat_tick, .heartbeat_send, .msg_start, .lan_reset, .watchdog_count_enable,
   .reboot_enable, .nmi_event, .nmi_enable, .global_mgmt_irq_enable, .nmi_out, .mgmt_interrupt_n,
   .bus_alert_n, .alert_event, .alert_source_enable, .intrusion_active, .intrusion_irq);
`default_nettype wire

// ===== shc_link_model.sv
// Management link stand-in: finishes each message after a short or long delay.
// Assumes msg_start is a one-cycle pulse; done never comes without a start.
`default_nettype none
module shc_link_model (
   input  wire logic clk_sys,
   input  wire logic nrst,
   input  wire logic msg_start,
   input  wire logic slow,
   output wire logic msg_done
);
   timeunit 1ns;
   timeprecision 1ns;
   int   left = 0;
   logic done_q = 1'b0;
   assign msg_done = done_q;
   always @(posedge clk_sys) begin
      done_q <= nrst && left == 1;
      if (!nrst) begin
         left <= 0;
      end else if (msg_start === 1'b1) begin
         left <= slow ? 9 : 2;
      end else if (left > 0) begin
         left <= left - 1;
      end
   end
endmodule
`default_nettype wire

// ===== test_system_health_control_regs.sv
// Self-checking bench for the health control register block.
// Assumes package, block, checker and link stand-in are compiled first.
`default_nettype none
module test_system_health_control_regs;
   timeunit 1ns;
   timeprecision 1ns;
   logic                 clk_sys = 1'b0, nrst = 1'b0, rsm_n = 1'b0, alert_n = 1'b1;
   logic                 nmi_en = 1'b0, gbl = 1'b0, slow = 1'b0, last_sw, done;
   logic                 ms, sw, hb, lan, cen, ren, nmi, mirq_n, aev, aen, irq;
   logic [3:0]           ev = 4'h0;
   logic [1:0]           route = 2'h0, rsel;
   logic [15:0]          m1 = 16'h0000, m2 = 16'h0008, d, rdat;
   shc_pkg::shc_io_req_t q = '0;
   int                   pc[6], bs[6], ndone = 0;
   int                   fail_count = 0, cmp_count = 0, seed = 66;
   always #25 clk_sys = ~clk_sys;
   shc_health_ctrl dut_u (.clk_sys(clk_sys), .nrst(nrst), .resume_reset_n(rsm_n), .io_req(q),
      .io_rdata(rdat), .msg_done(done), .hw_event_req(ev[0]), .heartbeat_tick(ev[1]),
      .msg_start(ms), .msg_sw_event(sw), .heartbeat_send(hb), .lan_reset(lan),
      .watchdog_count_enable(cen), .reboot_enable(ren), .nmi_event(ev[2]), .nmi_enable(nmi_en),
      .global_mgmt_irq_enable(gbl), .nmi_out(nmi), .mgmt_interrupt_n(mirq_n),
      .bus_alert_n(alert_n), .alert_event(aev), .alert_source_enable(aen),
      .intrusion_active(ev[3]), .intrusion_irq(irq), .health_irq_route_sel(rsel),
      .health_irq_route(route));
   shc_link_model link_u (.clk_sys(clk_sys), .nrst(nrst), .msg_start(ms), .slow(slow),
      .msg_done(done));
   // ********
   // Pulse counters and model upkeep
   // ********
   always @(posedge clk_sys) begin
      pc[0] += int'(nmi === 1'b1);
      pc[1] += int'(mirq_n === 1'b0);
      pc[2] += int'(irq === 1'b1);
      pc[3] += int'(lan === 1'b1);
      pc[4] += int'(ms === 1'b1);
      pc[5] += int'(hb === 1'b1);
      if (ms === 1'b1) last_sw = sw;
      if (done === 1'b1) begin
         ndone++;
         m1[10] = 1'b0;
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Model: send bit sticks until done, forced bit toggles on a written one
   task automatic wr(input logic [7:0] a, input logic [1:0] b, input logic [15:0] v);
      @(negedge clk_sys);
      q = '{a, 1'b1, 1'b0, b, v};
      @(negedge clk_sys);
      q.wr = 1'b0;
      if (a == 8'h08 && b[1]) begin
         m1 = m1 & 16'h0500 | v & 16'h0e00;
         m1[8] = m1[8] ^ v[8];
      end
      if (a == 8'h0a && b[0]) m2 = v & 16'h000e;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(negedge clk_sys);
      q = '{a, 1'b0, 1'b1, 2'h0, 16'h0};
      @(negedge clk_sys);
      q.rd = 1'b0;
      chk(rdat, e);
   endtask
   task automatic pulse(input int k);
      @(negedge clk_sys);
      ev[k] = 1'b1;
      @(negedge clk_sys);
      ev[k] = 1'b0;
   endtask
   // Order: nmi, mgmt, intrusion irq, lan reset, msg start, heartbeat; -1 skips
   task automatic span(input int e[6]);
      repeat (4) @(negedge clk_sys);
      foreach (e[k]) begin
         if (e[k] >= 0) chk(16'(pc[k] - bs[k]), 16'(e[k]));
      end
      bs = pc;
   endtask
   task automatic wait_done();
      int n0;
      n0 = ndone;
      for (int i = 0; i < 40 && ndone == n0; i++) @(negedge clk_sys);
      chk(16'(ndone - n0), 16'h0001);
   endtask
   task automatic final_report();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      #(50 * 4000);
      fail_count++;
      final_report();
   end
   initial begin
      repeat (20) @(negedge clk_sys);
      nrst = 1'b1;
      rsm_n = 1'b1;
      repeat (3) @(negedge clk_sys);
      bs = pc;
      rd(8'h08, m1);
      rd(8'h0a, m2);
      chk(16'(aen), 16'h0);
      wr(8'h0c, 2'h3, 16'hffff);
      rd(8'h0c, 16'h0);
      wr(8'h08, 2'h1, 16'hffff);
      rd(8'h08, m1);
      $display("reset and decode test done");
      for (int i = 0; i < 8; i++) begin
         d = 16'($random(seed));
         d[3:1] = i[2:0];
         route = d[15:14];
         wr(8'h0a, 2'h2, ~d);
         wr(8'h0a, 2'h1, d);
         rd(8'h0a, m2);
         chk(16'(aen), 16'(!i[2]));
         alert_n = 1'b0;
         repeat (2) @(negedge clk_sys);
         chk(16'(aev), 16'(!i[2]));
         alert_n = 1'b1;
         chk(16'(rsel), 16'(route));
         pulse(3);
         span('{0, i[1:0] == 2'h2, i[1:0] == 2'h1, 0, 0, 0});
      end
      $display("alert and intrusion test done");
      wr(8'h08, 2'h2, 16'hfaff);
      rd(8'h08, m1);
      chk(16'({cen, ren}), 16'h0);
      pulse(1);
      wr(8'h08, 2'h2, 16'h0e00);
      span('{0, 0, 0, 1, 0, 1});
      for (int j = 0; j < 4; j++) begin
         {gbl, nmi_en} = 2'(j);
         pulse(2);
         span('{0, j == 2, 0, 0, 0, 0});
      end
      // Request still pending, so the send bit is written as zero here
      wr(8'h08, 2'h2, 16'h0200);
      span('{0, 0, 0, 0, 1, 0});
      chk(16'(last_sw), 16'h1);
      wait_done();
      rd(8'h08, m1);
      chk(16'({cen, ren}), 16'h3);
      wr(8'h08, 2'h2, 16'h0000);
      {gbl, nmi_en} = 2'h2;
      pulse(2);
      span('{1, 0, 0, 0, 0, 0});
      slow = 1'b1;
      pulse(0);
      span('{0, 0, 0, 0, 1, 0});
      chk(16'(last_sw), 16'h0);
      wait_done();
      $display("halt and message test done");
      wr(8'h08, 2'h2, 16'h0100);
      span('{1, 0, 0, 0, 0, 0});
      wr(8'h08, 2'h2, 16'h0000);
      span('{0, 0, 0, 0, 0, 0});
      rd(8'h08, m1);
      wr(8'h08, 2'h2, 16'h0100);
      span('{0, 0, 0, 0, 0, 0});
      rd(8'h08, m1);
      wr(8'h08, 2'h2, 16'h0100);
      span('{1, 0, 0, 0, 0, 0});
      $display("forced interrupt test done");
      // Resume reset alone, mid-run: control two returns to its reset value
      rsm_n = 1'b0;
      repeat (2) @(negedge clk_sys);
      rsm_n = 1'b1;
      m2 = shc_pkg::CTRL_TWO_RST;
      repeat (3) @(negedge clk_sys);
      rd(8'h0a, m2);
      chk(16'(aen), 16'h0);
      $display("resume reset test done");
      final_report();
   end
endmodule
`default_nettype wire
